/* core/art_timer_regs.sv */
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "art_cfg.svh"

module art_timer_regs (
    input wire logic clk_sys,                 // System clock, 40 MHz
    input wire logic sys_rst,                 // Async reset, active high
    input wire logic halt_mode,               // Device in halt
    input wire logic cpu_irq_mask,            // Global interrupt mask
    input wire logic companion_ms_tick,       // 1 ms tick pulse
    input wire logic own_capture_pin,         // Own capture input
    input wire logic companion_capture_pin,   // Companion capture input
    input wire logic break_pin,               // Break input
    output logic [3:0] pwm_out,               // PWM pin levels
    output logic [3:0] pwm_oe,                // PWM owns the pin
    output logic irq_capture,                 // Capture request
    output logic irq_overflow,                // Overflow request
    output logic irq_compare,                 // Compare request
    input wire logic [7:0] s_axi_awaddr,      // Write address
    input wire logic [2:0] s_axi_awprot,      // Unused protection
    input wire logic s_axi_awvalid,           // Write address valid
    output logic s_axi_awready,               // Write address ready
    input wire logic [31:0] s_axi_wdata,      // Write data
    input wire logic [3:0] s_axi_wstrb,       // Write strobes
    input wire logic s_axi_wvalid,            // Write data valid
    output logic s_axi_wready,                // Write data ready
    output logic [1:0] s_axi_bresp,           // Write response
    output logic s_axi_bvalid,                // Write response valid
    input wire logic s_axi_bready,            // Write response ready
    input wire logic [7:0] s_axi_araddr,      // Read address
    input wire logic [2:0] s_axi_arprot,      // Unused protection
    input wire logic s_axi_arvalid,           // Read address valid
    output logic s_axi_arready,               // Read address ready
    output logic [31:0] s_axi_rdata,          // Read data
    output logic [1:0] s_axi_rresp,           // Read response
    output logic s_axi_rvalid,                // Read data valid
    input wire logic s_axi_rready             // Read data ready
);

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    function automatic logic [5:0] duty_idx(input int ch, input logic high);
        duty_idx = 6'(`ART_IDX_DUTY0H + 2 * ch + (high ? 0 : 1));
    endfunction : duty_idx

    function automatic logic [5:0] chcsr_idx(input int ch);
        chcsr_idx = 6'(`ART_IDX_CHCSR0 + ch);
    endfunction : chcsr_idx

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx >= `ART_IDX_TMRCS) && (idx <= `ART_IDX_CAPL);
    endfunction : mapped

    // ************************
    // State and scratch signals
    // ************************
    art_pkg::art_state_t s_ff;
    art_pkg::art_state_t nxt_s;

    logic tick;
    logic ovf_evt;
    logic cap_pin;
    logic op_trig;
    logic do_wr;
    logic [7:0] wbyte;
    logic [5:0] ridx;
    logic [7:0] rval;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_s = s_ff;
        tick = 1'b0;
        ovf_evt = 1'b0;
        op_trig = 1'b0;
        rval = 8'h00;
        ridx = s_axi_araddr[7:2];
        wbyte = s_ff.w_data;

        // ************************
        // Counter source; illegal code counts nothing
        // ************************
        if (!halt_mode) begin
            unique case (art_pkg::art_src_t'(s_ff.counter_source_sel))
                art_pkg::ART_SRC_MS: tick = companion_ms_tick;
                art_pkg::ART_SRC_CPU: tick = 1'b1;
                default: tick = 1'b0;
            endcase
        end

        // ************************
        // AXI write channel handshake
        // ************************
        if (s_axi_awvalid && !s_ff.aw_ok) begin
            nxt_s.aw_ok = 1'b1;
            nxt_s.aw_idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && !s_ff.w_ok) begin
            nxt_s.w_ok = 1'b1;
            nxt_s.w_data = s_axi_wdata[7:0];
            nxt_s.w_lane0 = s_axi_wstrb[0];
        end
        if (s_ff.bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end

        // ************************
        // Register writes, once address and data are both held
        // ************************
        do_wr = s_ff.aw_ok && s_ff.w_ok && !s_ff.bvalid;
        if (do_wr) begin
            nxt_s.aw_ok = 1'b0;
            nxt_s.w_ok = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = mapped(s_ff.aw_idx) ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
            if (s_ff.w_lane0) begin
                if (s_ff.aw_idx == `ART_IDX_TMRCS) begin
                    // Flags ignore writes
                    nxt_s.capture_irq_en = wbyte[`ART_B_CAPIE];
                    nxt_s.counter_source_sel = wbyte[`ART_B_SRC_HI:`ART_B_SRC_LO];
                    nxt_s.overflow_irq_en = wbyte[`ART_B_OVFIE];
                    nxt_s.compare_irq_en = wbyte[`ART_B_COMPARE_IRQ_EN];
                end
                if (s_ff.aw_idx == `ART_IDX_RLDH) begin
                    nxt_s.reload[11:8] = wbyte[3:0];
                end
                if (s_ff.aw_idx == `ART_IDX_RLDL) begin
                    nxt_s.reload[7:0] = wbyte;
                end
                if (s_ff.aw_idx == `ART_IDX_OECR) begin
                    for (int i = 0; i < 4; i++) begin
                        nxt_s.oe[i] = wbyte[i * `ART_OE_STRIDE];
                    end
                end
                for (int i = 0; i < 4; i++) begin
                    if (s_ff.aw_idx == chcsr_idx(i)) begin
                        nxt_s.pol_pre[i] = wbyte[`ART_B_POL];
                        if (i == `ART_CH_ONEPULSE) begin
                            nxt_s.one_pulse_en = wbyte[`ART_B_OPEN];
                            nxt_s.one_pulse_edge_sel = wbyte[`ART_B_ONE_PULSE_EDGE_SEL];
                        end
                    end
                    if (s_ff.aw_idx == duty_idx(i, 1'b1)) begin
                        nxt_s.duty_pre[i][11:8] = wbyte[3:0];
                    end
                    if (s_ff.aw_idx == duty_idx(i, 1'b0)) begin
                        nxt_s.duty_pre[i][7:0] = wbyte;
                    end
                end
                if (s_ff.aw_idx == `ART_IDX_BRKCR) begin
                    nxt_s.break_level_sel = wbyte[`ART_B_BRKLVL];
                    nxt_s.break_active = wbyte[`ART_B_BRKACT];
                    nxt_s.break_pin_en = wbyte[`ART_B_BRKPEN];
                    nxt_s.break_pattern = wbyte[3:0];
                end
                if (s_ff.aw_idx == `ART_IDX_CTRL2) begin
                    nxt_s.capture_source_sel = wbyte[`ART_B_CAPSEL];
                    // Transfer enable may only be set by software
                    if (wbyte[`ART_B_TRAN]) begin
                        nxt_s.preload_transfer_en = 1'b1;
                    end
                end
            end
        end

        // ************************
        // AXI read channel handshake
        // ************************
        if (s_ff.rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end

        // ************************
        // Read decode, clear-on-read at acceptance
        // ************************
        if (s_axi_arvalid && !s_ff.rvalid) begin
            if (ridx == `ART_IDX_TMRCS) begin
                rval[`ART_B_CAPF] = s_ff.capture_flag;
                rval[`ART_B_CAPIE] = s_ff.capture_irq_en;
                rval[`ART_B_SRC_HI:`ART_B_SRC_LO] = s_ff.counter_source_sel;
                rval[`ART_B_OVF] = s_ff.overflow_flag;
                rval[`ART_B_OVFIE] = s_ff.overflow_irq_en;
                rval[`ART_B_COMPARE_IRQ_EN] = s_ff.compare_irq_en;
                nxt_s.overflow_flag = 1'b0;
            end
            if (ridx == `ART_IDX_CNTH) begin
                rval[3:0] = s_ff.cnt[11:8];
            end
            if (ridx == `ART_IDX_CNTL) begin
                rval = s_ff.cnt[7:0];
            end
            if (ridx == `ART_IDX_RLDH) begin
                rval[3:0] = s_ff.reload[11:8];
            end
            if (ridx == `ART_IDX_RLDL) begin
                rval = s_ff.reload[7:0];
            end
            if (ridx == `ART_IDX_OECR) begin
                for (int i = 0; i < 4; i++) begin
                    rval[i * `ART_OE_STRIDE] = s_ff.oe[i];
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (ridx == chcsr_idx(i)) begin
                    rval[`ART_B_POL] = s_ff.pol_pre[i];
                    rval[`ART_B_CMPF] = s_ff.cmpf[i];
                    if (i == `ART_CH_ONEPULSE) begin
                        rval[`ART_B_OPEN] = s_ff.one_pulse_en;
                        rval[`ART_B_ONE_PULSE_EDGE_SEL] = s_ff.one_pulse_edge_sel;
                    end
                    nxt_s.cmpf[i] = 1'b0;
                end
                if (ridx == duty_idx(i, 1'b1)) begin
                    rval[3:0] = s_ff.duty_pre[i][11:8];
                end
                if (ridx == duty_idx(i, 1'b0)) begin
                    rval = s_ff.duty_pre[i][7:0];
                end
            end
            if (ridx == `ART_IDX_BRKCR) begin
                rval[`ART_B_BRKLVL] = s_ff.break_level_sel;
                rval[`ART_B_BRKACT] = s_ff.break_active;
                rval[`ART_B_BRKPEN] = s_ff.break_pin_en;
                rval[3:0] = s_ff.break_pattern;
            end
            if (ridx == `ART_IDX_CTRL2) begin
                rval[`ART_B_CAPSEL] = s_ff.capture_source_sel;
                rval[`ART_B_TRAN] = s_ff.preload_transfer_en;
            end
            if (ridx == `ART_IDX_CAPH || ridx == `ART_IDX_CAPL) begin
                rval = (ridx == `ART_IDX_CAPH) ? {4'h0, s_ff.captured_value[11:8]}
                                               : s_ff.captured_value[7:0];
                nxt_s.capture_flag = 1'b0;
            end
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = rval;
            nxt_s.rresp = mapped(ridx) ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
        end

        // ************************
        // One-pulse trigger, ignored while a pulse is in progress
        // ************************
        nxt_s.comp_prev = companion_capture_pin;
        if (s_ff.one_pulse_edge_sel) begin
            op_trig = companion_capture_pin && !s_ff.comp_prev;
        end else begin
            op_trig = !companion_capture_pin && s_ff.comp_prev;
        end
        op_trig = op_trig && s_ff.one_pulse_en && !s_ff.pwm_lvl[`ART_CH_ONEPULSE] && !halt_mode;

        // ************************
        // Counter, reload and compare
        // ************************
        if (op_trig) begin
            nxt_s.cnt = `ART_CNT_ZERO;
            nxt_s.pwm_lvl[3:2] = 2'h3;
            ovf_evt = 1'b1;
        end else if (tick) begin
            if (s_ff.cnt == `ART_CNT_MAX) begin
                nxt_s.cnt = s_ff.reload;
                nxt_s.pwm_lvl = 4'hf;
                ovf_evt = 1'b1;
            end else begin
                nxt_s.cnt = 12'(s_ff.cnt + 12'h001);
            end
        end
        if (ovf_evt) begin
            nxt_s.overflow_flag = 1'b1;
            if (s_ff.preload_transfer_en) begin
                nxt_s.duty_act = s_ff.duty_pre;
                nxt_s.pol_act = s_ff.pol_pre;
                nxt_s.preload_transfer_en = 1'b0;
            end
        end
        for (int i = 0; i < 4; i++) begin
            if ((tick || op_trig) && nxt_s.cnt == nxt_s.duty_act[i]) begin
                nxt_s.cmpf[i] = 1'b1;
                nxt_s.pwm_lvl[i] = 1'b0;
            end
        end

        // ************************
        // Input capture
        // ************************
        cap_pin = s_ff.capture_source_sel ? companion_capture_pin : own_capture_pin;
        nxt_s.cap_prev = cap_pin;
        if (!halt_mode && cap_pin != s_ff.cap_prev && !s_ff.capture_flag) begin
            nxt_s.captured_value = s_ff.cnt;
            nxt_s.capture_flag = 1'b1;
        end

        // ************************
        // Break detection, set wins over a software clear
        // ************************
        if (s_ff.break_pin_en && break_pin == s_ff.break_level_sel) begin
            nxt_s.break_active = 1'b1;
        end

        // ************************
        // Pin levels
        // ************************
        for (int i = 0; i < 4; i++) begin
            if (!nxt_s.oe[i]) begin
                nxt_s.pwm_out[i] = 1'b0;
            end else if (nxt_s.break_active) begin
                nxt_s.pwm_out[i] = nxt_s.break_pattern[i];
            end else begin
                nxt_s.pwm_out[i] = nxt_s.pwm_lvl[i] ^ nxt_s.pol_act[i];
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_ff <= '0;
            s_ff.preload_transfer_en <= `ART_TRAN_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign pwm_out = s_ff.pwm_out;
    assign pwm_oe = s_ff.oe;
    assign irq_capture = s_ff.capture_flag && s_ff.capture_irq_en && !cpu_irq_mask;
    assign irq_overflow = s_ff.overflow_flag && s_ff.overflow_irq_en && !cpu_irq_mask;
    assign irq_compare = (|s_ff.cmpf) && s_ff.compare_irq_en && !cpu_irq_mask;

    // ************************
    // Bus outputs
    // ************************
    assign s_axi_awready = !s_ff.aw_ok;
    assign s_axi_wready = !s_ff.w_ok;
    assign s_axi_bvalid = s_ff.bvalid;
    assign s_axi_bresp = s_ff.bresp;
    assign s_axi_arready = !s_ff.rvalid;
    assign s_axi_rvalid = s_ff.rvalid;
    assign s_axi_rresp = s_ff.rresp;
    assign s_axi_rdata = {24'h000000, s_ff.rdata};

endmodule : art_timer_regs

/* core/art_cfg.svh */
`ifndef ART_CFG_SVH
`define ART_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ART_IDX_TMRCS    6'h11
`define ART_IDX_CNTH     6'h12
`define ART_IDX_CNTL     6'h13
`define ART_IDX_RLDH     6'h14
`define ART_IDX_RLDL     6'h15
`define ART_IDX_OECR     6'h16
`define ART_IDX_CHCSR0   6'h17
`define ART_IDX_DUTY0H   6'h1b
`define ART_IDX_BRKCR    6'h23
`define ART_IDX_CTRL2    6'h24
`define ART_IDX_CAPH     6'h25
`define ART_IDX_CAPL     6'h26

// ****************************************************************
// Field positions
// ****************************************************************
`define ART_B_CAPF       6
`define ART_B_CAPIE      5
`define ART_B_SRC_HI     4
`define ART_B_SRC_LO     3
`define ART_B_OVF        2
`define ART_B_OVFIE      1
`define ART_B_COMPARE_IRQ_EN      0
`define ART_B_OPEN       3
`define ART_B_ONE_PULSE_EDGE_SEL     2
`define ART_B_POL        1
`define ART_B_CMPF       0
`define ART_B_BRKLVL     6
`define ART_B_BRKACT     5
`define ART_B_BRKPEN     4
`define ART_B_CAPSEL     5
`define ART_B_TRAN       0
`define ART_OE_STRIDE    2
`define ART_CH_ONEPULSE  3

// ****************************************************************
// Values
// ****************************************************************
`define ART_CNT_MAX      12'hfff
`define ART_CNT_ZERO     12'h000
`define ART_TRAN_RST     1'b1
`define ART_RESP_OKAY    2'b00
`define ART_RESP_SLVERR  2'b10

`endif

/* core/art_pkg.sv */
package art_pkg;

    typedef enum logic [1:0] {
        ART_SRC_OFF = 2'h0,
        ART_SRC_MS  = 2'h1,
        ART_SRC_CPU = 2'h2,
        ART_SRC_BAD = 2'h3
    } art_src_t;

    typedef struct packed {
        logic [11:0] cnt;
        logic [11:0] reload;
        logic [3:0] oe;
        logic [3:0][11:0] duty_pre;
        logic [3:0][11:0] duty_act;
        logic [3:0] pol_pre;
        logic [3:0] pol_act;
        logic [3:0] cmpf;
        logic one_pulse_en;
        logic one_pulse_edge_sel;
        logic capture_flag;
        logic capture_irq_en;
        logic [1:0] counter_source_sel;
        logic overflow_flag;
        logic overflow_irq_en;
        logic compare_irq_en;
        logic break_level_sel;
        logic break_active;
        logic break_pin_en;
        logic [3:0] break_pattern;
        logic [11:0] captured_value;
        logic capture_source_sel;
        logic preload_transfer_en;
        logic cap_prev;
        logic comp_prev;
        logic [3:0] pwm_lvl;
        logic [3:0] pwm_out;
        logic aw_ok;
        logic [5:0] aw_idx;
        logic w_ok;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } art_state_t;

endpackage : art_pkg

/* tb/art_timer_checker.sv */
`timescale 1ns/100ps
module art_timer_checker (
    input wire logic clk_sys, // Clock
    input wire logic sys_rst, // Reset
    input wire logic cpu_irq_mask, // Global mask
    input wire logic [3:0] pwm_out, // Pin levels
    input wire logic [3:0] pwm_oe, // Pin enables
    input wire logic irq_capture, // Capture request
    input wire logic irq_overflow, // Overflow request
    input wire logic irq_compare, // Compare request
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_cap_read;
        s_ar_taken ##0 (s_axi_araddr[7:2] == 6'h25 || s_axi_araddr[7:2] == 6'h26);
    endsequence
    sequence s_bad_read;
        s_ar_taken ##0 (s_axi_araddr[7:2] < 6'h11 || s_axi_araddr[7:2] > 6'h26);
    endsequence
    a_mask_quiets: assert property (cpu_irq_mask |->
        !(irq_capture || irq_overflow || irq_compare)) else $error("irq under mask");
    a_oe_frees_pin: assert property ((pwm_out & ~pwm_oe) == 4'h0)
        else $error("pwm driven while disabled");
    a_cap_read_clears: assert property (s_cap_read |=> !irq_capture)
        else $error("capture read kept flag");
    a_unmapped_err: assert property (s_bad_read |=>
        s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("bad read resp");
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid) else $error("read late");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule : art_timer_checker
bind art_timer_regs art_timer_checker u_art_timer_checker (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .cpu_irq_mask(cpu_irq_mask), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .irq_capture(irq_capture), .irq_overflow(irq_overflow), .irq_compare(irq_compare),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

/* tb/art_pin_model.sv */
`timescale 1ns/100ps
module art_pin_model (
    input wire logic clk_sys, // Clock
    output logic own_capture_pin, // Own capture input
    output logic companion_capture_pin, // Companion capture input
    output logic break_pin // Break input
);
    initial begin
        own_capture_pin = 1'b0;
        companion_capture_pin = 1'b0;
        break_pin = 1'b0;
    end
    task automatic toggle(input logic comp);
        @(posedge clk_sys);
        if (comp) companion_capture_pin <= ~companion_capture_pin;
        else own_capture_pin <= ~own_capture_pin;
    endtask : toggle
    task automatic set_break(input logic lvl);
        @(posedge clk_sys);
        break_pin <= lvl;
    endtask : set_break
endmodule : art_pin_model

/* tb/testbench.sv */
`timescale 1ns/100ps
`include "art_cfg.svh"
module testbench;
    logic clk_sys = 0, sys_rst = 1, halt = 0, mask = 0, tick = 0;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wr_, bv, arr, rv;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] bresp, rresp;
    logic [2:0] prot = 3'h0;
    logic [3:0] wst = 4'h1;
    logic [3:0] pwm_out, pwm_oe;
    logic irq_c, irq_o, irq_m, own_pin, comp_pin, brk_pin;
    int n_mismatch = 0, cmp_count = 0;
    always #12.5 clk_sys = ~clk_sys;
    art_timer_regs u_art_timer_regs (.clk_sys(clk_sys), .sys_rst(sys_rst), .halt_mode(halt),
        .cpu_irq_mask(mask), .companion_ms_tick(tick), .own_capture_pin(own_pin),
        .companion_capture_pin(comp_pin), .break_pin(brk_pin), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe), .irq_capture(irq_c), .irq_overflow(irq_o), .irq_compare(irq_m),
        .s_axi_awaddr(awa), .s_axi_awprot(prot), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wr_),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
        .s_axi_arprot(prot), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre));
    art_pin_model u_art_pin_model (.clk_sys(clk_sys), .own_capture_pin(own_pin),
        .companion_capture_pin(comp_pin), .break_pin(brk_pin));
    // ************************
    // Helpers
    // ************************
    task automatic stop_test;
        $display("Mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic lim(input int n);
        if (n >= 50) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
    endtask : lim
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic a, w, b;
        int n;
        @(posedge clk_sys);
        awa <= {idx, 2'b00};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_sys);
            a = awv && awr;
            w = wv && wr_;
            b = bv && bre;
            @(posedge clk_sys);
            if (a) awv <= 1'b0;
            if (w) wv <= 1'b0;
            if (b) bre <= 1'b0;
            n++;
        end while (!b && n < 50);
        lim(n);
    endtask : wr
    task automatic rdr(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
        logic a, b;
        int n;
        @(posedge clk_sys);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rre <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_sys);
            a = arv && arr;
            b = rv && rre;
            d = rd[7:0];
            r = rresp;
            @(posedge clk_sys);
            if (a) arv <= 1'b0;
            if (b) rre <= 1'b0;
            n++;
        end while (!b && n < 50);
        lim(n);
    endtask : rdr
    task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] d;
        logic [1:0] r;
        rdr(idx, d, r);
        chk(d, e);
    endtask : rdc
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            tick <= 1'b1;
            @(posedge clk_sys);
            tick <= 1'b0;
        end
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : ticks
    // ************************
    // Scenarios
    // ************************
    task automatic t_reset;
        logic [5:0] ix [12] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h1b,
            6'h23, 6'h24, 6'h25, 6'h26};
        logic [7:0] d;
        logic [1:0] r;
        foreach (ix[i]) rdc(ix[i], (ix[i] == `ART_IDX_CTRL2) ? 8'h01 : 8'h00);
        rdr(6'h00, d, r);
        chk({d, r}, {8'h00, `ART_RESP_SLVERR});
    endtask : t_reset
    task automatic t_count;
        logic [7:0] a, b, h;
        logic [1:0] r;
        wr(`ART_IDX_TMRCS, 8'h10);
        halt <= 1'b1;
        ticks(0);
        rdr(`ART_IDX_CNTL, a, r);
        rdr(`ART_IDX_CNTL, b, r);
        chk(b, a);
        halt <= 1'b0;
        rdr(`ART_IDX_CNTL, b, r);
        chk(a !== b, 1'b1);
        wr(`ART_IDX_TMRCS, 8'h0b);
        rdr(`ART_IDX_CNTL, a, r);
        rdr(`ART_IDX_CNTH, h, r);
        ticks(3);
        rdc(`ART_IDX_CNTL, 8'({h[3:0], a} + 12'h003));
        rdr(`ART_IDX_CNTH, h, r);
        rdr(`ART_IDX_CNTL, a, r);
        wr(`ART_IDX_RLDH, 8'h0f);
        wr(`ART_IDX_RLDL, 8'hfd);
        wr(`ART_IDX_OECR, 8'h01);
        wr(`ART_IDX_DUTY0H, 8'h0f);
        wr(`ART_IDX_DUTY0H + 6'h01, 8'hfe);
        ticks(int'(12'hfff - {h[3:0], a}));
        chk(irq_o, 1'b0);
        ticks(1);
        chk({irq_o, pwm_out}, 5'h11);
        rdc(`ART_IDX_CNTL, 8'hfd);
        rdc(`ART_IDX_CNTH, 8'h0f);
        ticks(1);
        chk({irq_m, pwm_out}, 5'h10);
        mask <= 1'b1;
        ticks(0);
        chk({irq_c, irq_o, irq_m}, 3'h0);
        mask <= 1'b0;
        rdc(`ART_IDX_TMRCS, 8'h0f);
        rdc(`ART_IDX_TMRCS, 8'h0b);
        rdc(`ART_IDX_CHCSR0, 8'h01);
        rdc(`ART_IDX_CHCSR0, 8'h00);
        wst <= 4'h0;
        wr(`ART_IDX_RLDL, 8'h00);
        wst <= 4'h1;
        rdc(`ART_IDX_RLDL, 8'hfd);
    endtask : t_count
    task automatic t_pol;
        wr(`ART_IDX_CHCSR0, 8'h02);
        wr(`ART_IDX_CTRL2, 8'h01);
        ticks(2);
        chk(pwm_out, 4'h0);
        rdc(`ART_IDX_CTRL2, 8'h00);
        ticks(1);
        chk(pwm_out, 4'h1);
    endtask : t_pol
    task automatic t_break;
        wr(`ART_IDX_BRKCR, 8'h50);
        u_art_pin_model.set_break(1'b1);
        ticks(0);
        chk(pwm_out, 4'h0);
        rdc(`ART_IDX_BRKCR, 8'h70);
        u_art_pin_model.set_break(1'b0);
        wr(`ART_IDX_BRKCR, 8'h50);
        ticks(0);
        chk(pwm_out, 4'h1);
        wr(`ART_IDX_BRKCR, 8'h10);
        ticks(0);
        chk(pwm_out, 4'h0);
        u_art_pin_model.set_break(1'b1);
        wr(`ART_IDX_BRKCR, 8'h40);
        ticks(0);
        chk(pwm_out, 4'h1);
        u_art_pin_model.set_break(1'b0);
    endtask : t_break
    task automatic t_cap;
        wr(`ART_IDX_TMRCS, 8'h2b);
        u_art_pin_model.toggle(1'b0);
        ticks(0);
        chk(irq_c, 1'b1);
        ticks(1);
        u_art_pin_model.toggle(1'b0);
        wr(`ART_IDX_TMRCS, 8'h2b);
        ticks(0);
        chk(irq_c, 1'b1);
        rdc(`ART_IDX_CAPH, 8'h0f);
        rdc(`ART_IDX_CAPL, 8'hfe);
        u_art_pin_model.toggle(1'b1);
        ticks(0);
        chk(irq_c, 1'b0);
        wr(`ART_IDX_CTRL2, 8'h20);
        u_art_pin_model.toggle(1'b1);
        ticks(0);
        chk(irq_c, 1'b1);
        wr(`ART_IDX_TMRCS, 8'h0b);
        ticks(0);
        chk(irq_c, 1'b0);
        rdc(`ART_IDX_CAPL, 8'hff);
    endtask : t_cap
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_count();
        t_pol();
        t_break();
        t_cap();
        stop_test();
    end
endmodule : testbench
